// file: hdl/motor_pwm_pkg.sv
package motor_pwm_pkg;

	// Clock and timing
	localparam int CLK_MHZ = 250;
	localparam int DEAD_NS = 500;
	localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
	localparam int SPI_BAUD_KHZ = 3120;
	localparam int SPI_HALF_CYC = (CLK_MHZ * 1000) / (2 * SPI_BAUD_KHZ);
	localparam logic [7:0] SPI_HALF = 8'(SPI_HALF_CYC);
	localparam logic [4:0] SPI_LAST_BIT = 5'h0F;

	// Prescalers
	localparam logic [1:0] SEQ_DIV_LAST = 2'h3;
	localparam logic [3:0] SLOW_DIV_LAST = 4'hF;
	localparam logic [3:0] CONV_TICKS_LAST = 4'h3;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PER_START = 8'h04;
	localparam logic [7:0] OFS_PER_END = 8'h08;
	localparam logic [7:0] OFS_RATIO = 8'h0C;
	localparam logic [7:0] OFS_DEAD = 8'h10;
	localparam logic [7:0] OFS_TRIG = 8'h14;
	localparam logic [7:0] OFS_DUTY0 = 8'h18;
	localparam logic [7:0] OFS_DUTY1 = 8'h1C;
	localparam logic [7:0] OFS_DUTY2 = 8'h20;
	localparam logic [7:0] OFS_SLOW_LIMIT = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam logic [7:0] OFS_RESULT_A = 8'h2C;
	localparam logic [7:0] OFS_RESULT_B = 8'h30;
	localparam logic [7:0] OFS_SPI_DATA = 8'h34;

	// Reset values
	localparam logic [15:0] RST_PER_START = 16'hEC78;
	localparam logic [15:0] RST_PER_END = 16'h1387;
	localparam logic [7:0] RST_RATIO = 8'h02;
	localparam logic [15:0] RST_DEAD = 16'(DEAD_CYC);
	localparam logic [15:0] RST_TRIG = 16'h000D;
	localparam logic [15:0] RST_SLOW_LIMIT = 16'h00FF;

	// Configuration that takes effect at master reload
	typedef struct packed {
		logic [15:0] per_start;
		logic [15:0] per_end;
		logic [7:0] ratio;
		logic [15:0] dead;
		logic [15:0] trig;
		logic [15:0] duty0;
		logic [15:0] duty1;
		logic [15:0] duty2;
	} cfg_s;

	localparam cfg_s CFG_RST = '{
		per_start: RST_PER_START,
		per_end: RST_PER_END,
		ratio: RST_RATIO,
		dead: RST_DEAD,
		trig: RST_TRIG,
		duty0: 16'h0000,
		duty1: 16'h0000,
		duty2: 16'h0000
	};

endpackage

// file: hdl/pwm_phase.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_phase (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic sync_i,
	input wire logic reload_i,
	input wire logic [15:0] start_i,
	input wire logic [15:0] end_i,
	input wire logic [15:0] dead_i,
	input wire logic [15:0] duty_i,
	input wire logic off_i,
	output logic top_n_o,
	output logic bot_o
);
	logic signed [15:0] cnt_q;
	logic signed [15:0] cmp_q;
	logic raw_q;
	logic [15:0] dt_q;
	wire logic signed [15:0] neg_cmp = -cmp_q;
	wire logic raw = (cnt_q >= neg_cmp) && (cnt_q < cmp_q);
	wire logic top_act = raw_q && (dt_q == 16'h0000) && !off_i;
	wire logic bot_act = !raw_q && (dt_q == 16'h0000) && !off_i;

	// Counter restarts on master sync, lockstep with master
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q <= $signed(motor_pwm_pkg::RST_PER_START);
		end else if (sync_i || cnt_q == $signed(end_i)) begin
			cnt_q <= $signed(start_i);
		end else begin
			cnt_q <= cnt_q + 16'sh0001;
		end
	end

	// Compare value loads only on master reload
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cmp_q <= 16'sh0000;
		end else if (reload_i) begin
			cmp_q <= $signed(duty_i);
		end
	end

	// Dead time after every edge of the raw waveform
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			raw_q <= 1'b0;
			dt_q <= 16'h0000;
		end else if (raw != raw_q) begin
			raw_q <= raw;
			dt_q <= dead_i;
		end else if (dt_q != 16'h0000) begin
			dt_q <= dt_q - 16'h0001;
		end
	end

	// Complementary pair, top active low, bottom active high
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			top_n_o <= 1'b1;
			bot_o <= 1'b0;
		end else begin
			top_n_o <= ~top_act;
			bot_o <= bot_act;
		end
	end
endmodule
`default_nettype wire

// file: hdl/scan_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module scan_sequencer (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic sync_i,
	input wire logic [11:0] sample_i,
	output logic conv_req_o,
	output logic conv_slot_o,
	output logic [11:0] res0_o,
	output logic [11:0] res1_o,
	output logic done_o
);
	typedef enum logic {SEQ_IDLE, SEQ_CONV} seq_state_e;
	seq_state_e state_q;
	logic [1:0] div_q;
	logic [3:0] tcnt_q;
	wire logic tick = (div_q == motor_pwm_pkg::SEQ_DIV_LAST);
	wire logic conv_end = tick && (tcnt_q == motor_pwm_pkg::CONV_TICKS_LAST);

	// Converter clock is the system clock divided by four
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end

	// One scan per sync, two slots in order
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= SEQ_IDLE;
			tcnt_q <= 4'h0;
			conv_req_o <= 1'b0;
			conv_slot_o <= 1'b0;
			res0_o <= 12'h000;
			res1_o <= 12'h000;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_q)
				SEQ_IDLE: begin
					if (sync_i) begin
						state_q <= SEQ_CONV;
						tcnt_q <= 4'h0;
						conv_req_o <= 1'b1;
						conv_slot_o <= 1'b0;
					end
				end
				SEQ_CONV: begin
					if (conv_end) begin
						tcnt_q <= 4'h0;
						if (conv_slot_o) begin
							res1_o <= sample_i;
							done_o <= 1'b1;
							conv_req_o <= 1'b0;
							state_q <= SEQ_IDLE;
						end else begin
							res0_o <= sample_i;
							conv_slot_o <= 1'b1;
						end
					end else if (tick) begin
						tcnt_q <= tcnt_q + 4'h1;
					end
				end
				default: begin
					state_q <= SEQ_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: hdl/motor_pwm_adc_sync.sv
// Summary of operation
// - PWM period is counter stepping from start value to end value.
// - Master reload issued only every nth reload opportunity, default two.
// - Phase and trigger values load only on master reload.
// - Phase counters resynchronised by master sync, counting in lockstep.
// - Trigger counter restarts on master reload, not master sync.
// - Trigger counter advances at half the master counter rate.
// - Trigger compare match asserts converter trigger, default setting 13.
// - Converter trigger drives sync inputs of both sequencers.
// - Each sequencer scans first and second slots, 12-bit, in order.
// - End-of-scan raised after sequencer A finishes both slots.
// - Sequencers run from the clock divided by four.
// - Six outputs, complementary top and bottom per phase.
// - Dead time inserted between complementary outputs, default 0.5 us.
// - High-side outputs active low, low-side outputs active high.
// - Fault disables all outputs; recovery at first reload opportunity after clear.
// - Slow timer on clock divided by 16, 0 to limit, tick at reload.
// - Default slow limit gives a slow tick every 4096 clocks, faster than the 10000-clock PWM period.
// - Gate driver serial port is master, 3.12 MHz, select active high.
`timescale 1ns/1ps
`default_nettype none
module motor_pwm_adc_sync (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [31:0] rd_data_o,
	input wire logic overcurrent_fault_input_i,
	output logic [2:0] pwm_top_n_o,
	output logic [2:0] pwm_bot_o,
	output logic converter_trigger_out_o,
	output logic conv_req_a_o,
	output logic conv_slot_a_o,
	input wire logic [11:0] sample_a_i,
	output logic conv_req_b_o,
	output logic conv_slot_b_o,
	input wire logic [11:0] sample_b_i,
	output logic end_of_scan_o,
	output logic slow_tick_o,
	output logic spi_sclk_o,
	output logic spi_mosi_o,
	output logic spi_cs1_o
);
	motor_pwm_pkg::cfg_s buf_q;
	motor_pwm_pkg::cfg_s act_q;
	logic run_q;
	logic [15:0] slow_limit_q;
	logic signed [15:0] mcnt_q;
	logic [7:0] opp_q;
	logic half_q;
	logic [15:0] tcnt_q;
	logic trig_done_q;
	logic f1_q;
	logic f2_q;
	logic f3_q;
	logic fault_lvl_q;
	logic fault_lat_q;
	logic [3:0] pre_q;
	logic [15:0] scnt_q;
	logic spi_busy_q;
	logic [7:0] spi_div_q;
	logic [4:0] spi_bit_q;
	logic [15:0] spi_sh_q;
	logic [11:0] res0_a;
	logic [11:0] res1_a;
	logic [11:0] res0_b;
	logic [11:0] res1_b;
	logic done_a;
	logic done_b;
	logic [31:0] rd_mux;

	// Address decode
	wire logic wr_ctrl = wr_en_i && addr_i == motor_pwm_pkg::OFS_CTRL;
	wire logic wr_start = wr_en_i && addr_i == motor_pwm_pkg::OFS_PER_START;
	wire logic wr_end = wr_en_i && addr_i == motor_pwm_pkg::OFS_PER_END;
	wire logic wr_ratio = wr_en_i && addr_i == motor_pwm_pkg::OFS_RATIO;
	wire logic wr_dead = wr_en_i && addr_i == motor_pwm_pkg::OFS_DEAD;
	wire logic wr_trig = wr_en_i && addr_i == motor_pwm_pkg::OFS_TRIG;
	wire logic wr_duty0 = wr_en_i && addr_i == motor_pwm_pkg::OFS_DUTY0;
	wire logic wr_duty1 = wr_en_i && addr_i == motor_pwm_pkg::OFS_DUTY1;
	wire logic wr_duty2 = wr_en_i && addr_i == motor_pwm_pkg::OFS_DUTY2;
	wire logic wr_slow = wr_en_i && addr_i == motor_pwm_pkg::OFS_SLOW_LIMIT;
	wire logic wr_spi = wr_en_i && addr_i == motor_pwm_pkg::OFS_SPI_DATA;

	// Master counter wrap is the reload opportunity and master sync
	wire logic wrap = (mcnt_q == $signed(act_q.per_end));
	wire logic [7:0] ratio_m1 = (act_q.ratio == 8'h00) ? 8'h00 :
		act_q.ratio - 8'h01;
	wire logic mreload = wrap && (opp_q == ratio_m1);
	wire logic outputs_off = fault_lat_q || !run_q;
	wire logic trig_hit = half_q && !trig_done_q && (tcnt_q == act_q.trig);
	wire logic slow_tick = (pre_q == motor_pwm_pkg::SLOW_DIV_LAST);
	// Limit lowered below the count still wraps at the next tick
	wire logic slow_wrap = slow_tick && (scnt_q >= slow_limit_q);
	wire logic spi_edge = spi_busy_q &&
		(spi_div_q == motor_pwm_pkg::SPI_HALF - 8'h01);

	// Buffered configuration written by software
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			buf_q <= motor_pwm_pkg::CFG_RST;
			run_q <= 1'b0;
			slow_limit_q <= motor_pwm_pkg::RST_SLOW_LIMIT;
		end else begin
			if (wr_ctrl) run_q <= wr_data_i[0];
			if (wr_start) buf_q.per_start <= wr_data_i[15:0];
			if (wr_end) buf_q.per_end <= wr_data_i[15:0];
			if (wr_ratio) buf_q.ratio <= wr_data_i[7:0];
			if (wr_dead) buf_q.dead <= wr_data_i[15:0];
			if (wr_trig) buf_q.trig <= wr_data_i[15:0];
			if (wr_duty0) buf_q.duty0 <= wr_data_i[15:0];
			if (wr_duty1) buf_q.duty1 <= wr_data_i[15:0];
			if (wr_duty2) buf_q.duty2 <= wr_data_i[15:0];
			if (wr_slow) slow_limit_q <= wr_data_i[15:0];
		end
	end

	// Active set follows the buffer only at master reload
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			act_q <= motor_pwm_pkg::CFG_RST;
		end else if (mreload) begin
			act_q <= buf_q;
		end
	end

	// Master counter from start to end value
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mcnt_q <= $signed(motor_pwm_pkg::RST_PER_START);
		end else if (wrap) begin
			mcnt_q <= $signed(act_q.per_start);
		end else begin
			mcnt_q <= mcnt_q + 16'sh0001;
		end
	end

	// Count opportunities, reload on every nth
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			opp_q <= 8'h00;
		end else if (mreload) begin
			opp_q <= 8'h00;
		end else if (wrap) begin
			opp_q <= opp_q + 8'h01;
		end
	end

	// Trigger counter at half rate, restarted by master reload
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			half_q <= 1'b0;
			tcnt_q <= 16'h0000;
			trig_done_q <= 1'b0;
		end else if (mreload) begin
			half_q <= 1'b0;
			tcnt_q <= 16'h0000;
			trig_done_q <= 1'b0;
		end else begin
			half_q <= ~half_q;
			if (half_q) tcnt_q <= tcnt_q + 16'h0001;
			if (trig_hit) trig_done_q <= 1'b1;
		end
	end

	// Converter trigger pulse on compare match
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			converter_trigger_out_o <= 1'b0;
		end else begin
			converter_trigger_out_o <= trig_hit;
		end
	end

	// Fault pin synchroniser, level counts when stages two and three agree
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			f1_q <= 1'b0;
			f2_q <= 1'b0;
			f3_q <= 1'b0;
			fault_lvl_q <= 1'b0;
		end else begin
			f1_q <= overcurrent_fault_input_i;
			f2_q <= f1_q;
			f3_q <= f2_q;
			if (f2_q == f3_q) fault_lvl_q <= f3_q;
		end
	end

	// Fault latch, set wins over the reload opportunity that would clear it
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			fault_lat_q <= 1'b0;
		end else if (fault_lvl_q) begin
			fault_lat_q <= 1'b1;
		end else if (wrap) begin
			fault_lat_q <= 1'b0;
		end
	end

	// Three phase submodules sharing master sync and reload
	// Duties come from the buffer; phases latch them at master reload
	logic [15:0] duty [3];
	assign duty[0] = buf_q.duty0;
	assign duty[1] = buf_q.duty1;
	assign duty[2] = buf_q.duty2;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_phase
			pwm_phase u_phase (
				.clk_i(clk_i),
				.sys_rst_i(sys_rst_i),
				.sync_i(wrap),
				.reload_i(mreload),
				.start_i(act_q.per_start),
				.end_i(act_q.per_end),
				.dead_i(act_q.dead),
				.duty_i(duty[gi]),
				.off_i(outputs_off),
				.top_n_o(pwm_top_n_o[gi]),
				.bot_o(pwm_bot_o[gi])
			);
		end
	endgenerate

	// Both sequencers start on the same trigger
	scan_sequencer u_seq_a (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.sync_i(converter_trigger_out_o),
		.sample_i(sample_a_i),
		.conv_req_o(conv_req_a_o),
		.conv_slot_o(conv_slot_a_o),
		.res0_o(res0_a),
		.res1_o(res1_a),
		.done_o(done_a)
	);
	scan_sequencer u_seq_b (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.sync_i(converter_trigger_out_o),
		.sample_i(sample_b_i),
		.conv_req_o(conv_req_b_o),
		.conv_slot_o(conv_slot_b_o),
		.res0_o(res0_b),
		.res1_o(res1_b),
		.done_o(done_b)
	);
	assign end_of_scan_o = done_a;

	// Slow-loop timer on divide-by-16 prescaler
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pre_q <= 4'h0;
			scnt_q <= 16'h0000;
			slow_tick_o <= 1'b0;
		end else begin
			pre_q <= pre_q + 4'h1;
			slow_tick_o <= slow_wrap;
			if (slow_wrap) begin
				scnt_q <= 16'h0000;
			end else if (slow_tick) begin
				scnt_q <= scnt_q + 16'h0001;
			end
		end
	end

	// Gate driver serial master, mode 0, MSB first, select active high
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			spi_busy_q <= 1'b0;
			spi_div_q <= 8'h00;
			spi_bit_q <= 5'h00;
			spi_sh_q <= 16'h0000;
			spi_sclk_o <= 1'b0;
			spi_cs1_o <= 1'b0;
		end else if (wr_spi && !spi_busy_q) begin
			spi_busy_q <= 1'b1;
			spi_sh_q <= wr_data_i[15:0];
			spi_div_q <= 8'h00;
			spi_bit_q <= 5'h00;
			spi_cs1_o <= 1'b1;
		end else if (spi_busy_q) begin
			spi_div_q <= spi_edge ? 8'h00 : spi_div_q + 8'h01;
			if (spi_edge && !spi_sclk_o) begin
				spi_sclk_o <= 1'b1;
			end else if (spi_edge) begin
				spi_sclk_o <= 1'b0;
				spi_sh_q <= {spi_sh_q[14:0], 1'b0};
				spi_bit_q <= spi_bit_q + 5'h01;
				if (spi_bit_q == motor_pwm_pkg::SPI_LAST_BIT) begin
					spi_busy_q <= 1'b0;
					spi_cs1_o <= 1'b0;
				end
			end
		end
	end
	assign spi_mosi_o = spi_sh_q[15];

	// Read selection, unmapped addresses read zero
	assign rd_mux =
		(addr_i == motor_pwm_pkg::OFS_CTRL) ? {31'h0, run_q} :
		(addr_i == motor_pwm_pkg::OFS_PER_START) ? {16'h0, buf_q.per_start} :
		(addr_i == motor_pwm_pkg::OFS_PER_END) ? {16'h0, buf_q.per_end} :
		(addr_i == motor_pwm_pkg::OFS_RATIO) ? {24'h0, buf_q.ratio} :
		(addr_i == motor_pwm_pkg::OFS_DEAD) ? {16'h0, buf_q.dead} :
		(addr_i == motor_pwm_pkg::OFS_TRIG) ? {16'h0, buf_q.trig} :
		(addr_i == motor_pwm_pkg::OFS_DUTY0) ? {16'h0, buf_q.duty0} :
		(addr_i == motor_pwm_pkg::OFS_DUTY1) ? {16'h0, buf_q.duty1} :
		(addr_i == motor_pwm_pkg::OFS_DUTY2) ? {16'h0, buf_q.duty2} :
		(addr_i == motor_pwm_pkg::OFS_SLOW_LIMIT) ? {16'h0, slow_limit_q} :
		(addr_i == motor_pwm_pkg::OFS_STATUS) ?
			{29'h0, spi_busy_q, fault_lvl_q, fault_lat_q} :
		(addr_i == motor_pwm_pkg::OFS_RESULT_A) ?
			{4'h0, res1_a, 4'h0, res0_a} :
		(addr_i == motor_pwm_pkg::OFS_RESULT_B) ?
			{4'h0, res1_b, 4'h0, res0_b} :
		32'h0000_0000;

	// Read data registered, valid the cycle after the strobe only
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_data_o <= 32'h0000_0000;
		end else begin
			rd_data_o <= rd_en_i ? rd_mux : 32'h0000_0000;
		end
	end

	// Sequencer B completion is not an event of its own
	logic unused_done_b;
	assign unused_done_b = done_b;
endmodule
`default_nettype wire

// file: verif/motor_pwm_adc_sync_chk.sv
`timescale 1ns/1ps
`default_nettype none
module motor_pwm_adc_sync_chk (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic overcurrent_fault_input_i,
	input wire logic [2:0] pwm_top_n_o,
	input wire logic [2:0] pwm_bot_o,
	input wire logic converter_trigger_out_o,
	input wire logic conv_req_a_o,
	input wire logic conv_slot_a_o,
	input wire logic conv_req_b_o,
	input wire logic end_of_scan_o,
	input wire logic spi_sclk_o,
	input wire logic spi_mosi_o,
	input wire logic spi_cs1_o
);
	// One clock domain for every check
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// Output pair and dead time checks
	a_pair_exclusive: assert property ((~pwm_top_n_o & pwm_bot_o) == 3'h0)
		else $error("top and bottom on together");
	a_dead_after_bot: assert property ($fell(pwm_bot_o[0]) |-> pwm_top_n_o[0] [*8])
		else $error("top switched on inside dead time");
	a_fault_off: assert property (overcurrent_fault_input_i [*8] |=>
		(pwm_top_n_o == 3'h7 && pwm_bot_o == 3'h0))
		else $error("outputs active during fault");

	// Trigger and scan checks
	a_trig_single: assert property (converter_trigger_out_o |=> !converter_trigger_out_o)
		else $error("trigger longer than one cycle");
	a_scan_start: assert property ($rose(converter_trigger_out_o) |->
		##[1:8] (conv_req_a_o && conv_req_b_o))
		else $error("scan did not start on both sequencers");
	a_slot_first: assert property ($rose(conv_req_a_o) |-> !conv_slot_a_o)
		else $error("scan did not begin at first slot");
	a_slot_last: assert property ($fell(conv_req_a_o) |-> $past(conv_slot_a_o))
		else $error("scan ended before second slot");
	a_eos_late: assert property ((conv_req_a_o && !conv_slot_a_o) |-> !end_of_scan_o)
		else $error("end of scan during first slot");

	// Serial port checks
	a_spi_select: assert property (spi_sclk_o |-> spi_cs1_o)
		else $error("serial clock without select");
	a_spi_mode: assert property ($rose(spi_sclk_o) |-> $stable(spi_mosi_o))
		else $error("data changed at rising serial clock");

	// Main scenarios reached
	c_trigger: cover property ($rose(converter_trigger_out_o));
	c_scan_end: cover property (end_of_scan_o);
	c_fault: cover property (overcurrent_fault_input_i [*8]);
	c_spi_done: cover property ($fell(spi_cs1_o));
endmodule

bind motor_pwm_adc_sync motor_pwm_adc_sync_chk u_chk (
	.clk_i,
	.sys_rst_i,
	.overcurrent_fault_input_i,
	.pwm_top_n_o,
	.pwm_bot_o,
	.converter_trigger_out_o,
	.conv_req_a_o,
	.conv_slot_a_o,
	.conv_req_b_o,
	.end_of_scan_o,
	.spi_sclk_o,
	.spi_mosi_o,
	.spi_cs1_o
);
`default_nettype wire

// file: verif/power_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module power_stage_model #(
	parameter logic [11:0] A0 = 12'h3C2,
	parameter logic [11:0] A1 = 12'hA51,
	parameter logic [11:0] B0 = 12'h1E7,
	parameter logic [11:0] B1 = 12'h6B4
) (
	input wire logic clk_i,
	input wire logic fault_cmd_i,
	output logic fault_o,
	input wire logic req_a_i,
	input wire logic slot_a_i,
	input wire logic req_b_i,
	input wire logic slot_b_i,
	output logic [11:0] sample_a_o,
	output logic [11:0] sample_b_o,
	input wire logic sclk_i,
	input wire logic mosi_i,
	input wire logic cs1_i,
	output logic [15:0] rx_o
);
	logic noise_q = 1'b0;

	// Idle converter lines toggle every cycle
	always @(posedge clk_i) noise_q <= ~noise_q;
	assign sample_a_o = req_a_i ? (slot_a_i ? A1 : A0) : {12{noise_q}};
	assign sample_b_o = req_b_i ? (slot_b_i ? B1 : B0) : {12{~noise_q}};

	// Overcurrent level, active high
	assign fault_o = fault_cmd_i;

	// Gate driver takes bits MSB first while selected high
	always @(posedge sclk_i) if (cs1_i) rx_o <= {rx_o[14:0], mosi_i};
endmodule
`default_nettype wire

// file: verif/motor_pwm_adc_sync_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module motor_pwm_adc_sync_tb_top;
	localparam logic [11:0] A0 = 12'h3C2;
	localparam logic [11:0] A1 = 12'hA51;
	localparam logic [11:0] B0 = 12'h1E7;
	localparam logic [11:0] B1 = 12'h6B4;
	logic clk_i, sys_rst_i, wr_en_i, rd_en_i, fault_cmd;
	logic [7:0] addr_i;
	logic [31:0] wr_data_i, rd_data_o;
	logic overcurrent_fault_input_i, converter_trigger_out_o, end_of_scan_o;
	logic [2:0] pwm_top_n_o, pwm_bot_o;
	logic conv_req_a_o, conv_slot_a_o, conv_req_b_o, conv_slot_b_o;
	logic [11:0] sample_a_i, sample_b_i;
	logic slow_tick_o, spi_sclk_o, spi_mosi_o, spi_cs1_o, act, lk;
	logic [15:0] spi_rx;
	int error_cnt = 0, checks = 0, cyc = 0, t0, t1, t2, t3, i;
	logic [7:0] ra [8] = '{motor_pwm_pkg::OFS_CTRL, motor_pwm_pkg::OFS_PER_START,
		motor_pwm_pkg::OFS_PER_END, motor_pwm_pkg::OFS_RATIO,
		motor_pwm_pkg::OFS_DEAD, motor_pwm_pkg::OFS_TRIG,
		motor_pwm_pkg::OFS_SLOW_LIMIT, 8'h3C};
	logic [31:0] rv [8] = '{32'h0, 32'hEC78, 32'h1387, 32'h2, 32'h7D, 32'hD,
		32'hFF, 32'h0};

	motor_pwm_adc_sync DUT (.clk_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_en_i,
		.rd_en_i, .rd_data_o, .overcurrent_fault_input_i, .pwm_top_n_o,
		.pwm_bot_o, .converter_trigger_out_o, .conv_req_a_o, .conv_slot_a_o,
		.sample_a_i, .conv_req_b_o, .conv_slot_b_o, .sample_b_i,
		.end_of_scan_o, .slow_tick_o, .spi_sclk_o, .spi_mosi_o, .spi_cs1_o);

	power_stage_model #(.A0(A0), .A1(A1), .B0(B0), .B1(B1)) u_stage (
		.clk_i(clk_i), .fault_cmd_i(fault_cmd),
		.fault_o(overcurrent_fault_input_i),
		.req_a_i(conv_req_a_o), .slot_a_i(conv_slot_a_o),
		.req_b_i(conv_req_b_o), .slot_b_i(conv_slot_b_o),
		.sample_a_o(sample_a_i), .sample_b_o(sample_b_i),
		.sclk_i(spi_sclk_o), .mosi_i(spi_mosi_o), .cs1_i(spi_cs1_o),
		.rx_o(spi_rx));

	// Clock and hang guard
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			error_cnt++;
			final_report();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task final_report();
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1'b1;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1;
		check(rd_data_o, e);
	endtask

	// Waits for trigger, end of scan, slow tick or select release
	task wait_ev(input int sel, output int t);
		logic s;
		s = 1'b0;
		for (int n = 0; n < 30000 && s !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
			case (sel)
				0: s = converter_trigger_out_o;
				1: s = end_of_scan_o;
				2: s = slow_tick_o;
				default: s = !spi_cs1_o;
			endcase
		end
		if (s !== 1'b1) error_cnt++;
		t = cyc;
	endtask

	initial begin
		clk_i = 1'b0;
		sys_rst_i = 1'b1;
		addr_i = 8'h00;
		wr_data_i = 32'h0;
		wr_en_i = 1'b0;
		rd_en_i = 1'b0;
		fault_cmd = 1'b0;
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		// Reset values and an unmapped address
		for (i = 0; i < 8; i++) rd(ra[i], rv[i]);
		// Period of 2000 cycles, equal duties, then run
		wr(motor_pwm_pkg::OFS_PER_START, 32'hFC18);
		wr(motor_pwm_pkg::OFS_PER_END, 32'h3E7);
		for (i = 0; i < 3; i++) wr(motor_pwm_pkg::OFS_DUTY0 + 8'(4 * i), 32'h190);
		wr(motor_pwm_pkg::OFS_CTRL, 32'h1);
		rd(motor_pwm_pkg::OFS_PER_END, 32'h3E7);
		wait_ev(0, t0);
		wait_ev(0, t0);
		// Scan results land in slot order
		wait_ev(1, t1);
		rd(motor_pwm_pkg::OFS_RESULT_A, {4'h0, A1, 4'h0, A0});
		rd(motor_pwm_pkg::OFS_RESULT_B, {4'h0, B1, 4'h0, B0});
		// Trigger delay moves by two clocks per step
		wr(motor_pwm_pkg::OFS_TRIG, 32'h32);
		wait_ev(0, t1);
		check(32'(t1 - t0), 32'(4000 + 2 * (50 - 13)));
		wr(motor_pwm_pkg::OFS_RATIO, 32'h3);
		wait_ev(0, t2);
		wait_ev(0, t3);
		check(32'(t2 - t1), 32'd4000);
		check(32'(t3 - t2), 32'd6000);
		// Fault shuts outputs and holds across a reload
		@(posedge clk_i);
		fault_cmd <= 1'b1;
		repeat (12) @(posedge clk_i);
		#1;
		check({pwm_top_n_o, pwm_bot_o}, 6'h38);
		rd(motor_pwm_pkg::OFS_STATUS, 32'h3);
		wait_ev(0, t0);
		check({pwm_top_n_o, pwm_bot_o}, 6'h38);
		@(posedge clk_i);
		fault_cmd <= 1'b0;
		act = 1'b0;
		lk = 1'b1;
		repeat (2300) begin
			@(posedge clk_i);
			#1;
			if ((~pwm_top_n_o | pwm_bot_o) != 3'h0) act = 1'b1;
			if (pwm_bot_o !== 3'h0 && pwm_bot_o !== 3'h7) lk = 1'b0;
		end
		check(act, 1'b1);
		check(lk, 1'b1);
		rd(motor_pwm_pkg::OFS_STATUS, 32'h0);
		// Gate driver transfer
		wr(motor_pwm_pkg::OFS_SPI_DATA, 32'hA5C3);
		rd(motor_pwm_pkg::OFS_STATUS, 32'h4);
		// A second word while busy must be ignored
		wr(motor_pwm_pkg::OFS_SPI_DATA, 32'h5A5A);
		wait_ev(3, t0);
		check({16'h0, spi_rx}, 32'hA5C3);
		// Slow tick spacing from prescale and limit
		wr(motor_pwm_pkg::OFS_SLOW_LIMIT, 32'h4);
		wait_ev(2, t0);
		wait_ev(2, t1);
		check(32'(t1 - t0), 32'(16 * 5));
		final_report();
	end
endmodule
`default_nettype wire
